//--- hdl/bfl_exec.sv
// execution unit for rotate, shift, swap, flag, bit transfer and load operations
// assumes an Avalon-MM master on the same clock and a data memory that
// returns read data in the cycle after its read strobe
`timescale 1ns/1ps

module bfl_exec #(
    parameter int unsigned NREG = 32
) (
    input  wire logic                       i_mclk,
    input  wire logic                       i_sys_rst,
    input  wire logic [bfl_pkg::BUS_AW-1:0] i_address,
    input  wire logic                       i_read,
    input  wire logic                       i_write,
    input  wire logic [31:0]                i_writedata,
    input  wire logic [3:0]                 i_byteenable,
    output logic      [31:0]                o_readdata,
    output logic                            o_waitrequest,
    output logic                            o_dm_rd,
    output logic      [bfl_pkg::DM_AW-1:0]  o_dm_addr,
    input  wire logic [7:0]                 i_dm_rdata
);
    import bfl_pkg::*;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0]       rf [NREG];
    bfl_cmd_s         cmd;
    logic [15:0]      arg;
    logic [7:0]       flg;
    logic [4:0]       ridx;
    bfl_state_e       state;

    bfl_cmd_s         next_cmd;
    logic             wr_acc;
    logic             start;
    logic             can_take;
    logic [31:0]      rd_val;
    logic [4:0]       next_lo;
    logic [15:0]      next_ptr;
    logic [15:0]      next_addr;
    logic [4:0]       cur_lo;
    logic [15:0]      cur_ptr;
    logic [7:0]       opval;
    logic [7:0]       res;
    logic             res_we;
    logic [7:0]       next_flg;
    logic [31:0]      arg_merged;
    logic [15:0]      ptr_inc;
    logic [15:0]      ptr_dec;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge_be

    function automatic logic [4:0] ptr_lo(input bfl_ptr_e p);
        logic [4:0] lo;
        lo = X_LO;
        if (p == PTR_Y) begin
            lo = Y_LO;
        end else if (p == PTR_Z) begin
            lo = Z_LO;
        end
        return lo;
    endfunction : ptr_lo

    // a pointer load is only legal with a real pointer; offsets use Y or Z only; a direct load is always legal
    function automatic logic load_ok(input bfl_cmd_s c);
        logic ok;
        ok = 1'b0;
        if (c.op == OP_DIRECT) begin
            ok = 1'b1;
        end else if (c.op == OP_PTR_OFF) begin
            ok = (c.ptr == PTR_Y) || (c.ptr == PTR_Z);
        end else if (c.op == OP_PTR_PLAIN || c.op == OP_PTR_INC || c.op == OP_PTR_DEC) begin
            ok = (c.ptr != PTR_N);
        end
        return ok;
    endfunction : load_ok

    // Z, N, V and S after a right shift; C is the bit shifted out
    function automatic logic [7:0] shift_flags(input logic [7:0] s, input logic [7:0] r,
                                               input logic c);
        logic [7:0] f;
        f         = s;
        f[FLAG_C] = c;
        f[FLAG_Z] = (r == 8'h00);
        f[FLAG_N] = r[7];
        f[FLAG_V] = r[7] ^ c;
        f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        return f;
    endfunction : shift_flags

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // a request completes on the edge that sees waitrequest low
    assign wr_acc   = i_write && !o_waitrequest;
    assign start    = wr_acc && (i_address == OFF_CMD);
    assign can_take = (state == ST_IDLE) || (i_read && (i_address == OFF_STAT));
    assign next_cmd = bfl_cmd_s'(merge_be(cmd, i_writedata, i_byteenable));
    assign arg_merged = merge_be({16'h0000, arg}, i_writedata, i_byteenable);

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (i_address == OFF_CMD) begin
            rd_val = cmd;
        end else if (i_address == OFF_ARG) begin
            rd_val = {16'h0000, arg};
        end else if (i_address == OFF_STAT) begin
            rd_val = {23'h00_0000, (state != ST_IDLE), flg};
        end else if (i_address == OFF_RIDX) begin
            rd_val = {27'h000_0000, ridx};
        end else if (i_address == OFF_RDAT) begin
            rd_val = {24'h00_0000, rf[ridx]};
        end
    end

    // one wait cycle per access; stalls all but status reads while an operation runs
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_waitrequest <= 1'b1;
        end else if (!o_waitrequest) begin
            o_waitrequest <= 1'b1;
        end else if ((i_read || i_write) && can_take) begin
            o_waitrequest <= 1'b0;
        end
    end

    // read data loaded as the grant is given, stands at the completing edge
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_readdata <= 32'h0000_0000;
        end else if (o_waitrequest && i_read && can_take) begin
            o_readdata <= rd_val;
        end
    end

    // command, argument and register index
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cmd  <= bfl_cmd_s'(CMD_RST);
            arg  <= ARG_RST;
            ridx <= RIDX_RST;
        end else if (wr_acc) begin
            if (i_address == OFF_CMD) begin
                cmd <= next_cmd;
            end else if (i_address == OFF_ARG) begin
                arg <= arg_merged[15:0];
            end else if (i_address == OFF_RIDX && i_byteenable[0]) begin
                ridx <= i_writedata[4:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= load_ok(next_cmd) ? ST_MEM1 : ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state <= ST_IDLE;
                end
                ST_MEM1: begin
                    state <= ST_MEM2;
                end
                ST_MEM2: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // load addressing
    // ------------------------------------------------------------------
    assign next_lo  = ptr_lo(next_cmd.ptr);
    assign next_ptr = {rf[{next_lo[4:1], 1'b1}], rf[next_lo]};
    assign cur_lo   = ptr_lo(cmd.ptr);
    assign cur_ptr  = {rf[{cur_lo[4:1], 1'b1}], rf[cur_lo]};
    assign ptr_inc  = cur_ptr + PTR_ONE;
    assign ptr_dec  = cur_ptr - PTR_ONE;

    // effective address of a load at its start
    always_comb begin
        next_addr = next_ptr;
        if (next_cmd.op == OP_PTR_DEC) begin
            next_addr = next_ptr - PTR_ONE;
        end else if (next_cmd.op == OP_PTR_OFF) begin
            next_addr = next_ptr + {10'h000, arg[5:0]};
        end else if (next_cmd.op == OP_DIRECT) begin
            next_addr = arg;
        end
    end

    // data memory read strobe for the first load cycle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_dm_rd   <= 1'b0;
            o_dm_addr <= '0;
        end else if (start && load_ok(next_cmd) && state == ST_IDLE) begin
            o_dm_rd   <= 1'b1;
            o_dm_addr <= next_addr;
        end else begin
            o_dm_rd   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // single-cycle operations
    // ------------------------------------------------------------------
    assign opval = rf[cmd.rd];

    always_comb begin
        res       = opval;
        res_we    = 1'b0;
        next_flg  = flg;
        case (cmd.op)
            OP_ROTR: begin
                res       = {flg[FLAG_C], opval[7:1]};
                res_we    = 1'b1;
                next_flg  = shift_flags(flg, {flg[FLAG_C], opval[7:1]}, opval[0]);
            end
            OP_SHRA: begin
                res       = {opval[7], opval[7:1]};
                res_we    = 1'b1;
                next_flg  = shift_flags(flg, {opval[7], opval[7:1]}, opval[0]);
            end
            OP_SWAP: begin
                res    = {opval[3:0], opval[7:4]};
                res_we = 1'b1;
            end
            OP_TSAVE: begin
                next_flg[FLAG_T] = opval[cmd.bit_sel];
            end
            OP_TLOAD: begin
                res               = opval;
                res[cmd.bit_sel]  = flg[FLAG_T];
                res_we            = 1'b1;
            end
            OP_VSET: next_flg[FLAG_V] = 1'b1;
            OP_VCLR: next_flg[FLAG_V] = 1'b0;
            OP_SSET: next_flg[FLAG_S] = 1'b1;
            OP_SCLR: next_flg[FLAG_S] = 1'b0;
            OP_HSET: next_flg[FLAG_H] = 1'b1;
            OP_HCLR: next_flg[FLAG_H] = 1'b0;
            default: begin
                res_we = 1'b0;
            end
        endcase
    end

    // status flags: operations in execute, software writes when idle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            flg <= FLG_RST;
        end else if (state == ST_EXEC) begin
            flg <= next_flg;
        end else if (wr_acc && i_address == OFF_STAT && i_byteenable[0]) begin
            flg <= i_writedata[7:0];
        end
    end

    // working registers: load data, pointer update, results, software window
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < NREG; i++) begin
                rf[i] <= REG_RST;
            end
        end else if (state == ST_MEM2) begin
            rf[cmd.rd] <= i_dm_rdata;
        end else if (state == ST_MEM1 && cmd.op == OP_PTR_INC) begin
            rf[cur_lo]                 <= ptr_inc[7:0];
            rf[{cur_lo[4:1], 1'b1}]    <= ptr_inc[15:8];
        end else if (state == ST_MEM1 && cmd.op == OP_PTR_DEC) begin
            rf[cur_lo]                 <= ptr_dec[7:0];
            rf[{cur_lo[4:1], 1'b1}]    <= ptr_dec[15:8];
        end else if (state == ST_EXEC && res_we) begin
            rf[cmd.rd] <= res;
        end else if (wr_acc && i_address == OFF_RDAT && i_byteenable[0]) begin
            rf[ridx] <= i_writedata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [7:0]  h_val;
    logic [7:0]  h_flg;
    logic [15:0] h_ptr;
    logic [7:0]  h_dm;

    // snapshots one cycle back for the checks below
    always_ff @(posedge i_mclk) begin
        h_val  <= opval;
        h_flg  <= flg;
        h_ptr  <= cur_ptr;
        h_dm   <= i_dm_rdata;
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence s_load_body;
        state == ST_MEM1 ##1 state == ST_MEM2 ##1 state == ST_IDLE;
    endsequence

    a_rotr_result: assert property ((state == ST_EXEC && cmd.op == OP_ROTR) |=>
        rf[cmd.rd] == {h_flg[FLAG_C], h_val[7:1]} && flg[FLAG_C] == h_val[0]
        && flg[FLAG_S] == (flg[FLAG_N] ^ flg[FLAG_V])
        && flg[FLAG_Z] == (rf[cmd.rd] == 8'h00) && state == ST_IDLE)
        else $error("rotate right result or carry wrong");
    a_tsave_flag: assert property ((state == ST_EXEC && cmd.op == OP_TSAVE) |=>
        flg[FLAG_T] == h_val[cmd.bit_sel] && flg[5:0] == h_flg[5:0])
        else $error("bit store did not copy bit into T");
    a_tload_bit: assert property ((state == ST_EXEC && cmd.op == OP_TLOAD) |=>
        rf[cmd.rd][cmd.bit_sel] == h_flg[FLAG_T] && flg == h_flg)
        else $error("bit load did not copy T into register");
    a_ovf_setclr: assert property ((state == ST_EXEC && (cmd.op == OP_VSET ||
        cmd.op == OP_VCLR)) |=> flg[FLAG_V] == (cmd.op == OP_VSET))
        else $error("overflow flag set or clear wrong");
    a_sign_setclr: assert property ((state == ST_EXEC && (cmd.op == OP_SSET ||
        cmd.op == OP_SCLR)) |=> flg[FLAG_S] == (cmd.op == OP_SSET))
        else $error("signed flag set or clear wrong");
    a_half_setclr: assert property ((state == ST_EXEC && (cmd.op == OP_HSET ||
        cmd.op == OP_HCLR)) |=> flg[FLAG_H] == (cmd.op == OP_HSET))
        else $error("half carry set or clear wrong");
    a_load_postinc: assert property ((state == ST_MEM1 && cmd.op == OP_PTR_INC) |->
        o_dm_addr == cur_ptr && o_dm_rd ##1 cur_ptr == h_ptr + PTR_ONE)
        else $error("post increment load wrong");
    a_load_predec: assert property ((state == ST_MEM1 && cmd.op == OP_PTR_DEC) |->
        o_dm_addr == cur_ptr - PTR_ONE ##1 cur_ptr == h_ptr - PTR_ONE)
        else $error("pre decrement load wrong");
    a_load_disp: assert property ((state == ST_MEM1 && cmd.op == OP_PTR_OFF) |->
        s_load_body and (o_dm_addr == cur_ptr + {10'h000, arg[5:0]} ##1 cur_ptr == h_ptr))
        else $error("offset load address or pointer wrong");
    a_load_direct: assert property ((state == ST_MEM1 && cmd.op == OP_DIRECT) |->
        o_dm_addr == arg ##1 flg == h_flg ##1 rf[cmd.rd] == h_dm && flg == h_flg)
        else $error("direct load wrong or flags changed");
    a_shra_result: assert property ((state == ST_EXEC && cmd.op == OP_SHRA) |=>
        rf[cmd.rd] == {h_val[7], h_val[7:1]} && flg[FLAG_C] == h_val[0])
        else $error("arithmetic shift right wrong");
    a_swap_nibble: assert property ((state == ST_EXEC && cmd.op == OP_SWAP) |=>
        rf[cmd.rd] == {h_val[3:0], h_val[7:4]} && flg == h_flg)
        else $error("nibble swap wrong or flags changed");

endmodule : bfl_exec

//--- inc/bfl_pkg.sv
// constants, types and layouts for the bit, flag and load execution unit
// assumes a single core clock and a synchronous active-high reset
//
// Summary of operation
// - rotate right through carry: old carry to bit 7, bit 0 to carry, Z C N V S
// - bit store copies a chosen source bit into T, other flags untouched, one cycle
// - bit load writes T into a chosen destination bit, flags untouched, one cycle
// - overflow flag set or cleared by its own operations in one cycle
// - signed test flag set or cleared by its own operations in one cycle
// - half-carry flag set or cleared by its own operations in one cycle
// - pointer load with post-increment reads at X, Y or Z then adds one, two cycles
// - pointer load with pre-decrement subtracts one then reads at new pointer, two cycles
// - offset load reads at Y or Z plus q, pointer kept, two cycles
// - direct load reads at a given address, no flag changes, two cycles
package bfl_pkg;

    // ------------------------------------------------------------------
    // register map, byte addresses on the register bus
    // ------------------------------------------------------------------
    localparam int unsigned   BUS_AW    = 5;
    localparam int unsigned   DM_AW     = 16;
    localparam logic [4:0]    OFF_CMD   = 5'h00;
    localparam logic [4:0]    OFF_ARG   = 5'h04;
    localparam logic [4:0]    OFF_STAT  = 5'h08;
    localparam logic [4:0]    OFF_RIDX  = 5'h0C;
    localparam logic [4:0]    OFF_RDAT  = 5'h10;

    // ------------------------------------------------------------------
    // status flag register layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned   FLAG_C    = 0;
    localparam int unsigned   FLAG_Z    = 1;
    localparam int unsigned   FLAG_N    = 2;
    localparam int unsigned   FLAG_V    = 3;
    localparam int unsigned   FLAG_S    = 4;
    localparam int unsigned   FLAG_H    = 5;
    localparam int unsigned   FLAG_T    = 6;
    localparam logic [7:0]    FLG_RST   = 8'h00;
    localparam logic [7:0]    REG_RST   = 8'h00;
    localparam logic [31:0]   CMD_RST   = 32'h0000_0000;
    localparam logic [15:0]   ARG_RST   = 16'h0000;
    localparam logic [4:0]    RIDX_RST  = 5'h00;
    localparam logic [15:0]   PTR_ONE   = 16'h0001;

    // low byte index of each pointer pair in the working registers
    localparam logic [4:0]    X_LO      = 5'h1A;
    localparam logic [4:0]    Y_LO      = 5'h1C;
    localparam logic [4:0]    Z_LO      = 5'h1E;

    typedef enum logic [1:0] {
        PTR_X = 2'b00,
        PTR_Y = 2'b01,
        PTR_Z = 2'b10,
        PTR_N = 2'b11
    } bfl_ptr_e;

    typedef enum logic [4:0] {
        OP_NOP       = 5'b00000,
        OP_ROTR      = 5'b00001,
        OP_SHRA      = 5'b00010,
        OP_SWAP      = 5'b00011,
        OP_TSAVE     = 5'b00100,
        OP_TLOAD     = 5'b00101,
        OP_VSET      = 5'b00110,
        OP_VCLR      = 5'b00111,
        OP_SSET      = 5'b01000,
        OP_SCLR      = 5'b01001,
        OP_HSET      = 5'b01010,
        OP_HCLR      = 5'b01011,
        OP_PTR_PLAIN = 5'b01100,
        OP_PTR_INC   = 5'b01101,
        OP_PTR_DEC   = 5'b01110,
        OP_PTR_OFF   = 5'b01111,
        OP_DIRECT    = 5'b10000
    } bfl_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_MEM1 = 2'b10,
        ST_MEM2 = 2'b11
    } bfl_state_e;

    // command word written at OFF_CMD
    typedef struct packed {
        logic [9:0] rsv3;
        bfl_ptr_e   ptr;
        logic       rsv2;
        logic [2:0] bit_sel;
        logic [2:0] rsv1;
        logic [4:0] rd;
        logic [2:0] rsv0;
        bfl_op_e    op;
    } bfl_cmd_s;

endpackage : bfl_pkg

//--- tb/bfl_dm_model.sv
// data memory stand-in for the load port of the execution unit
// assumes one-cycle read strobes and data taken one edge later
`timescale 1ns/1ps

module bfl_dm_model (
    input  wire logic        i_mclk,
    input  wire logic        i_dm_rd,
    input  wire logic [15:0] i_dm_addr,
    output logic      [7:0]  o_dm_rdata,
    output logic      [15:0] o_last_addr
);
    // ----------------------------------------------------------------
    // content is a hash of the address, valid for one cycle only
    // ----------------------------------------------------------------
    initial o_dm_rdata = 8'h00;
    initial o_last_addr = 16'h0000;
    // outside the valid cycle the data toggles so a value taken one edge late does not match
    always @(posedge i_mclk) begin
        if (i_dm_rd) begin
            o_dm_rdata  <= i_dm_addr[7:0] ^ i_dm_addr[15:8] ^ 8'h5A;
            o_last_addr <= i_dm_addr;
        end else begin
            o_dm_rdata <= ~o_dm_rdata;
        end
    end
endmodule : bfl_dm_model

//--- tb/bit_flag_load_exec_tb_top.sv
// self-checking bench for bfl_exec: random and corner operations over Avalon
// assumes bfl_pkg is compiled first and bfl_dm_model stands in for memory
`timescale 1ns/1ps

module bit_flag_load_exec_tb_top;
    import bfl_pkg::*;

    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    logic        i_mclk;
    logic        i_sys_rst = 1'b1;
    logic [4:0]  i_address = 5'h00;
    logic        i_read = 1'b0;
    logic        i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [31:0] o_readdata;
    logic        o_waitrequest;
    logic        o_dm_rd;
    logic [15:0] o_dm_addr;
    logic [7:0]  i_dm_rdata;
    logic [15:0] last_addr;
    logic [31:0] q;
    int          n_errors = 0;
    int          check_count = 0;

    bfl_exec u_bfl_exec (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_dm_rd(o_dm_rd),
        .o_dm_addr(o_dm_addr), .i_dm_rdata(i_dm_rdata));
    bfl_dm_model u_bfl_dm_model (.i_mclk(i_mclk), .i_dm_rd(o_dm_rd), .i_dm_addr(o_dm_addr),
        .o_dm_rdata(i_dm_rdata), .o_last_addr(last_addr));

    // 200 MHz core clock
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    // ----------------------------------------------------------------
    // comparisons, bus cycles and expectations
    // ----------------------------------------------------------------
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // one Avalon access, held until waitrequest is seen low; read data into q
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_mclk);
        i_read      <= !wr;
        i_write     <= wr;
        i_address   <= a;
        i_writedata <= d;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            n_errors++;
            $display("BAD waitrequest expected 0 seen %b", o_waitrequest);
        end
        q = o_readdata;
        i_read  <= 1'b0;
        i_write <= 1'b0;
    endtask : bus

    task automatic set_reg(input logic [4:0] r, input logic [7:0] v);
        bus(1'b1, OFF_RIDX, {27'h0, r});
        bus(1'b1, OFF_RDAT, {24'h0, v});
    endtask : set_reg

    task automatic get_reg(input logic [4:0] r);
        bus(1'b1, OFF_RIDX, {27'h0, r});
        bus(1'b0, OFF_RDAT, 32'h0);
    endtask : get_reg

    // issue a command and poll the busy bit with a bounded count
    task automatic run(input bfl_op_e op, input logic [4:0] rd, input logic [2:0] b,
                       input logic [1:0] p);
        bfl_cmd_s c;
        int       n = 0;
        c = '0;
        c.op = op;
        c.rd = rd;
        c.bit_sel = b;
        c.ptr = bfl_ptr_e'(p);
        bus(1'b1, OFF_CMD, 32'(c));
        do begin
            bus(1'b0, OFF_STAT, 32'h0);
            n++;
        end while (q[8] !== 1'b0 && n < 20);
        chk8("busy", 8'h00, {7'h0, q[8]});
    endtask : run

    function automatic logic [15:0] exp_alu(bfl_op_e op, logic [7:0] v, logic [7:0] f,
                                            logic [2:0] b);
        logic [7:0] r = v;
        logic [7:0] g = f;
        case (op)
            OP_ROTR, OP_SHRA: begin
                r = {(op == OP_ROTR) ? f[FLAG_C] : v[7], v[7:1]};
                g[FLAG_C] = v[0];
                g[FLAG_Z] = (r == 8'h00);
                g[FLAG_N] = r[7];
                g[FLAG_V] = r[7] ^ v[0];
                g[FLAG_S] = g[FLAG_N] ^ g[FLAG_V];
            end
            OP_SWAP: r = {v[3:0], v[7:4]};
            OP_TSAVE: g[FLAG_T] = v[b];
            OP_TLOAD: r[b] = f[FLAG_T];
            OP_VSET: g[FLAG_V] = 1'b1;
            OP_VCLR: g[FLAG_V] = 1'b0;
            OP_SSET: g[FLAG_S] = 1'b1;
            OP_SCLR: g[FLAG_S] = 1'b0;
            OP_HSET: g[FLAG_H] = 1'b1;
            OP_HCLR: g[FLAG_H] = 1'b0;
            default: r = v;
        endcase
        return {g, r};
    endfunction : exp_alu

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        logic [7:0]  v;
        logic [7:0]  f;
        logic [2:0]  b;
        logic [4:0]  rd;
        logic [4:0]  lo;
        logic [1:0]  p;
        logic [15:0] e;
        logic [15:0] base;
        logic [15:0] ea;
        logic [15:0] np;
        logic [15:0] arg;
        int          kind;
        void'($urandom(93));
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        bus(1'b0, OFF_STAT, 32'h0);
        chk16("status at reset", {8'h00, FLG_RST}, q[15:0]);
        bus(1'b0, 5'h14, 32'h0);
        chk16("unmapped read", 16'h0000, q[15:0]);
        get_reg(5'h07);
        chk8("register at reset", REG_RST, q[7:0]);
        $display("test reset done");
        for (int i = 0; i < 44; i++) begin
            v = (i < 11) ? 8'(i % 2) : 8'($urandom);
            f = 8'($urandom);
            b = 3'($urandom);
            rd = 5'($urandom % 26);
            set_reg(rd, v);
            bus(1'b1, OFF_STAT, {24'h0, f});
            run(bfl_op_e'(5'(1 + i % 11)), rd, b, 2'b00);
            e = exp_alu(bfl_op_e'(5'(1 + i % 11)), v, f, b);
            get_reg(rd);
            chk8("result", e[7:0], q[7:0]);
            bus(1'b0, OFF_STAT, 32'h0);
            chk8("flags", e[15:8], q[7:0]);
        end
        $display("test alu done");
        for (int i = 0; i < 25; i++) begin
            kind = i % 5;
            p = (kind == 3) ? 2'(1 + $urandom % 2) : 2'($urandom % 3);
            base = (i == 1) ? 16'hFFFF : (i == 2) ? 16'h0000 : 16'($urandom);
            arg = (kind == 3) ? 16'($urandom % 64) : 16'($urandom);
            rd = 5'($urandom % 26);
            f = 8'($urandom);
            lo = 5'(X_LO + 5'(2 * p));
            set_reg(lo, base[7:0]);
            set_reg(5'(lo + 5'h01), base[15:8]);
            bus(1'b1, OFF_ARG, {16'h0, arg});
            bus(1'b1, OFF_STAT, {24'h0, f});
            run(bfl_op_e'(5'(12 + kind)), rd, 3'h0, p);
            ea = (kind == 2) ? 16'(base - 16'h0001) : base;
            np = (kind == 1) ? 16'(base + 16'h0001) : ea;
            if (kind == 3) ea = 16'(base + {10'h0, arg[5:0]});
            if (kind == 4) ea = arg;
            chk16("memory address", ea, last_addr);
            get_reg(rd);
            chk8("loaded data", ea[7:0] ^ ea[15:8] ^ 8'h5A, q[7:0]);
            get_reg(lo);
            e[7:0] = q[7:0];
            get_reg(5'(lo + 5'h01));
            chk16("pointer", np, {q[7:0], e[7:0]});
            bus(1'b0, OFF_STAT, 32'h0);
            chk8("flags after load", f, q[7:0]);
        end
        // offset load through X is refused: no memory read, register kept
        set_reg(5'h05, 8'hA5);
        run(OP_PTR_OFF, 5'h05, 3'h0, 2'b00);
        chk16("refused load address", ea, last_addr);
        get_reg(5'h05);
        chk8("refused load data", 8'hA5, q[7:0]);
        $display("test load done");
        end_of_test();
    end

    // cuts a hang short well after the expected run length
    initial begin
        repeat (40000) @(posedge i_mclk);
        n_errors++;
        $display("BAD watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule : bit_flag_load_exec_tb_top
